// [rtl/pts_defines.svh]
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH
// How it works
// - The timer runs from the instruction clock, one tick per four cycles, via the prescaler.
// - The prescaler divides by one, four or sixteen as prescale_select chooses.
// - tick_count is an 8-bit register that steps up by one on each prescaler pulse.
// - period_value is an 8-bit register that holds the terminal count.
// - tick_count is compared with period_value always and counts up from zero to a match.
// - When the two are equal, the next increment loads zero instead of adding one.
// - Every match moves the postscaler on by one.
// - The postscaler divides by any whole ratio from one to sixteen per postscale_select.
// - The postscaler pulse sets period_match_flag, which drives irq while the mask bit is one.
// - Software may read and write tick_count and period_value at any time.
// - Reset loads tick_count with zero and period_value with all ones.
// - The timer counts only while timer_run is one; clearing it stops the timer.
// - Writes to tick_count or timer_control_reg, and reset, clear both scalers.
// - A write to timer_control_reg does not load tick_count; a prescaler pulse in the same cycle still steps it.

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PTS_ADDR_COUNT   4'h0
`define PTS_ADDR_PERIOD  4'h1
`define PTS_ADDR_CTRL    4'h2
`define PTS_ADDR_FLAG    4'h3
`define PTS_ADDR_MASK    4'h4

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define PTS_CTRL_PRE_LSB   0
`define PTS_CTRL_PRE_MSB   1
`define PTS_CTRL_RUN_BIT   2
`define PTS_CTRL_POST_LSB  3
`define PTS_CTRL_POST_MSB  6
`define PTS_CTRL_WMASK     8'h7f
`define PTS_FLAG_MATCH_BIT 0
`define PTS_COUNT_RST      8'h00
`define PTS_PERIOD_RST     8'hff
`define PTS_CTRL_RST       8'h00
`define PTS_MASK_RST       8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PTS_INSTR_DIV      2'h3
`define PTS_PRE4_LAST      4'h3
`define PTS_PRE16_LAST     4'hf
`endif

// [rtl/pts_pkg.sv]
package pts_pkg;
  typedef enum logic [2:0] {
    PTS_PRE_1  = 3'b001,
    PTS_PRE_4  = 3'b010,
    PTS_PRE_16 = 3'b100
  } pts_pre_t;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic       flag;
    logic [1:0] instr_div;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic [7:0] rdata;
  } pts_state_t;
endpackage

// [rtl/pts_timer.sv]
// Implementation choices: the address-and-strobe port and the address map.
`include "pts_defines.svh"

module pts_timer (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  output logic            irq
);
  import pts_pkg::*;

  // ------------------------------------------------------------
  // Decoders
  // ------------------------------------------------------------
  function automatic pts_pre_t pre_mode(input logic [1:0] sel);
    case (sel)
      2'h0:    pre_mode = PTS_PRE_1;
      2'h1:    pre_mode = PTS_PRE_4;
      default: pre_mode = PTS_PRE_16;
    endcase
  endfunction

  function automatic logic [3:0] pre_last(input pts_pre_t m);
    case (m)
      PTS_PRE_1:  pre_last = 4'h0;
      PTS_PRE_4:  pre_last = `PTS_PRE4_LAST;
      PTS_PRE_16: pre_last = `PTS_PRE16_LAST;
      default:    pre_last = 4'h0;
    endcase
  endfunction

  pts_state_t s_r;
  pts_state_t s_nxt;
  logic       instr_tick;
  logic       pre_tick;
  logic       match;
  logic       post_pulse;
  logic       wr_count;
  logic       wr_ctrl;
  logic       rd_flag;
  logic       run;
  logic [7:0] rd_mux;

  assign run        = s_r.ctrl[`PTS_CTRL_RUN_BIT];
  assign instr_tick = run && (s_r.instr_div == `PTS_INSTR_DIV);
  assign pre_tick   = instr_tick &&
                      (s_r.pre_cnt == pre_last(pre_mode(
                        s_r.ctrl[`PTS_CTRL_PRE_MSB:`PTS_CTRL_PRE_LSB])));
  assign match      = s_r.count == s_r.period;
  assign post_pulse = pre_tick && match &&
                      (s_r.post_cnt == s_r.ctrl[`PTS_CTRL_POST_MSB:`PTS_CTRL_POST_LSB]);
  assign wr_count   = wr_stb && (addr == `PTS_ADDR_COUNT);
  assign wr_ctrl    = wr_stb && (addr == `PTS_ADDR_CTRL);
  assign rd_flag    = rd_stb && (addr == `PTS_ADDR_FLAG);

  always_comb begin
    case (addr)
      `PTS_ADDR_COUNT:  rd_mux = s_r.count;
      `PTS_ADDR_PERIOD: rd_mux = s_r.period;
      `PTS_ADDR_CTRL:   rd_mux = s_r.ctrl;
      `PTS_ADDR_FLAG:   rd_mux = {7'h00, s_r.flag};
      `PTS_ADDR_MASK:   rd_mux = s_r.mask;
      default:          rd_mux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (run) begin
      s_nxt.instr_div = s_r.instr_div + 2'h1;
    end
    // Counting holds while stopped
    if (instr_tick) begin
      if (pre_tick) begin
        s_nxt.pre_cnt = 4'h0;
        if (match) begin
          s_nxt.count = 8'h00;
          if (post_pulse) begin
            s_nxt.post_cnt = 4'h0;
          end else begin
            s_nxt.post_cnt = s_r.post_cnt + 4'h1;
          end
        end else begin
          s_nxt.count = s_r.count + 8'h01;
        end
      end else begin
        s_nxt.pre_cnt = s_r.pre_cnt + 4'h1;
      end
    end
    // Read of the flag register clears; a new pulse wins
    if (rd_flag) begin
      s_nxt.flag = 1'b0;
    end
    if (post_pulse) begin
      s_nxt.flag = 1'b1;
    end
    if (wr_stb) begin
      case (addr)
        `PTS_ADDR_COUNT:  s_nxt.count = wdata;
        `PTS_ADDR_PERIOD: s_nxt.period = wdata;
        `PTS_ADDR_CTRL:   s_nxt.ctrl = wdata & `PTS_CTRL_WMASK;
        `PTS_ADDR_MASK:   s_nxt.mask = {7'h00, wdata[`PTS_FLAG_MATCH_BIT]};
        default:          s_nxt.ctrl = s_nxt.ctrl;
      endcase
    end
    if (wr_count || wr_ctrl) begin
      s_nxt.pre_cnt   = 4'h0;
      s_nxt.post_cnt  = 4'h0;
      s_nxt.instr_div = 2'h0;
    end
    s_nxt.rdata = rd_stb ? rd_mux : 8'h00;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r.count     <= `PTS_COUNT_RST;
      s_r.period    <= `PTS_PERIOD_RST;
      s_r.ctrl      <= `PTS_CTRL_RST;
      s_r.mask      <= `PTS_MASK_RST;
      s_r.flag      <= 1'b0;
      s_r.instr_div <= 2'h0;
      s_r.pre_cnt   <= 4'h0;
      s_r.post_cnt  <= 4'h0;
      s_r.rdata     <= 8'h00;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign irq   = s_r.flag && s_r.mask[`PTS_FLAG_MATCH_BIT];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_match_tick;
    clk_en && pre_tick && match && !wr_count;
  endsequence

  sequence s_count_step;
    clk_en && pre_tick && !match && !wr_count;
  endsequence

  sequence s_ctrl_quiet;
    clk_en && run && !wr_count && !wr_ctrl;
  endsequence

  // One instruction tick, then three quiet running cycles
  sequence s_instr_cycle;
    clk_en && instr_tick ##1 s_ctrl_quiet [*3];
  endsequence

  sequence s_post_advance;
    clk_en && pre_tick && match && !post_pulse && !wr_count && !wr_ctrl;
  endsequence

  sequence s_post_wrap;
    clk_en && post_pulse && !wr_count && !wr_ctrl;
  endsequence

  sequence s_flag_read;
    clk_en && rd_flag && !post_pulse;
  endsequence

  sequence s_scaler_write;
    clk_en && (wr_count || wr_ctrl);
  endsequence

  property p_wrap_zero;
    @(posedge mclk) disable iff (srst)
    s_match_tick |=> s_r.count == `PTS_COUNT_RST;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("count did not wrap to zero");

  property p_count_inc;
    @(posedge mclk) disable iff (srst)
    s_count_step |=> s_r.count == $past(s_r.count) + 8'h01;
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("count did not increment");

  property p_stop_hold;
    @(posedge mclk) disable iff (srst)
    !run && !wr_stb |=> $stable(s_r.count) && $stable(s_r.pre_cnt);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stopped timer moved");

  property p_no_tick_stop;
    @(posedge mclk) disable iff (srst)
    !run |-> !pre_tick && !post_pulse;
  endproperty
  a_no_tick_stop: assert property (p_no_tick_stop)
    else $error("tick while stopped");

  property p_wr_prio;
    @(posedge mclk) disable iff (srst)
    clk_en && wr_count |=> s_r.count == $past(wdata);
  endproperty
  a_wr_prio: assert property (p_wr_prio)
    else $error("count write lost");

  property p_scaler_clr;
    @(posedge mclk) disable iff (srst)
    s_scaler_write |=> s_r.pre_cnt == 4'h0 && s_r.post_cnt == 4'h0;
  endproperty
  a_scaler_clr: assert property (p_scaler_clr)
    else $error("scalers not cleared");

  property p_ctrl_keep;
    @(posedge mclk) disable iff (srst)
    clk_en && wr_ctrl && !instr_tick |=> $stable(s_r.count);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep)
    else $error("control write changed count");

  property p_flag_set;
    @(posedge mclk) disable iff (srst)
    clk_en && post_pulse |=> s_r.flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set");

  property p_reset_vals;
    @(posedge mclk)
    srst |=> s_r.count == `PTS_COUNT_RST && s_r.period == `PTS_PERIOD_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("bad reset values");

  property p_pre_bound;
    @(posedge mclk) disable iff (srst)
    s_r.pre_cnt <= pre_last(pre_mode(s_r.ctrl[`PTS_CTRL_PRE_MSB:`PTS_CTRL_PRE_LSB]));
  endproperty
  a_pre_bound: assert property (p_pre_bound)
    else $error("prescaler beyond its ratio");

  property p_instr_gap;
    @(posedge mclk) disable iff (srst)
    s_instr_cycle |=> instr_tick;
  endproperty
  a_instr_gap: assert property (p_instr_gap)
    else $error("instruction tick not every fourth cycle");

  property p_instr_single;
    @(posedge mclk) disable iff (srst)
    clk_en && instr_tick |=> !instr_tick;
  endproperty
  a_instr_single: assert property (p_instr_single)
    else $error("instruction tick too long");

  property p_post_step;
    @(posedge mclk) disable iff (srst)
    s_post_advance |=> s_r.post_cnt == $past(s_r.post_cnt) + 4'h1;
  endproperty
  a_post_step: assert property (p_post_step)
    else $error("postscaler did not advance");

  property p_post_restart;
    @(posedge mclk) disable iff (srst)
    s_post_wrap |=> s_r.post_cnt == 4'h0;
  endproperty
  a_post_restart: assert property (p_post_restart)
    else $error("postscaler did not restart");

  property p_post_bound;
    @(posedge mclk) disable iff (srst)
    s_r.post_cnt <= s_r.ctrl[`PTS_CTRL_POST_MSB:`PTS_CTRL_POST_LSB];
  endproperty
  a_post_bound: assert property (p_post_bound)
    else $error("postscaler beyond its ratio");

  property p_flag_clear;
    @(posedge mclk) disable iff (srst)
    s_flag_read |=> !s_r.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag read did not clear");

  property p_flag_keep;
    @(posedge mclk) disable iff (srst)
    clk_en && s_r.flag && !rd_flag |=> s_r.flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("flag dropped without a read");

  property p_period_wr;
    @(posedge mclk) disable iff (srst)
    clk_en && wr_stb && (addr == `PTS_ADDR_PERIOD) |=> s_r.period == $past(wdata);
  endproperty
  a_period_wr: assert property (p_period_wr)
    else $error("period write lost");

  property p_ctrl_wr;
    @(posedge mclk) disable iff (srst)
    clk_en && wr_ctrl |=> s_r.ctrl == ($past(wdata) & `PTS_CTRL_WMASK);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr)
    else $error("control write lost");

  property p_freeze_all;
    @(posedge mclk) disable iff (srst)
    !clk_en |=> $stable(s_r);
  endproperty
  a_freeze_all: assert property (p_freeze_all)
    else $error("state moved while clock enable low");

  property p_read_data;
    @(posedge mclk) disable iff (srst)
    clk_en && rd_stb |=> rdata == $past(rd_mux);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data wrong");

  property p_read_idle;
    @(posedge mclk) disable iff (srst)
    clk_en && !rd_stb |=> rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data stands too long");

  property p_reset_clear;
    @(posedge mclk)
    srst |=> s_r.pre_cnt == 4'h0 && s_r.post_cnt == 4'h0 && rdata == 8'h00 && !irq;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left scalers or outputs set");

  property p_stop_div;
    @(posedge mclk) disable iff (srst)
    !run && !wr_count && !wr_ctrl |=> $stable(s_r.instr_div) && $stable(s_r.post_cnt);
  endproperty
  a_stop_div: assert property (p_stop_div)
    else $error("stopped timer phase moved");

  property p_unmapped_keep;
    @(posedge mclk) disable iff (srst)
    clk_en && wr_stb && (addr > `PTS_ADDR_MASK) |=>
      $stable(s_r.period) && $stable(s_r.ctrl) && $stable(s_r.mask);
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep)
    else $error("unmapped write changed a register");
endmodule

// [verif/pts_timer_tb_top.sv]
`include "pts_defines.svh"

module pts_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, srst, clk_en, wr_stb, rd_stb, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv;
  int         n_mismatch, checks, cyc, t0;

  pts_timer dut (.mclk(mclk), .srst(srst), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(negedge mclk) cyc++;

  // ----------------------------------------
  // Bus tasks, one idle cycle after each
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge mclk) wr_stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(logic [3:0] a);
    addr <= a; rd_stb <= 1'b1;
    @(posedge mclk) rd_stb <= 1'b0;
    #1 rv = rdata;
    @(posedge mclk);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge mclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] exp [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0]);
      chk("reset/unmapped", rv, a < 5 ? exp[a] : 0);
    end
    wr(`PTS_ADDR_PERIOD, 8'h5a); wr(`PTS_ADDR_COUNT, 8'ha5); wr(4'h6, 8'h11);
    rd(`PTS_ADDR_PERIOD); chk("period", rv, 8'h5a);
    rd(`PTS_ADDR_COUNT); chk("count", rv, 8'ha5);
    rd(4'h6); chk("unmapped", rv, 0);
    wr(`PTS_ADDR_CTRL, 8'hff); rd(`PTS_ADDR_CTRL); chk("ctrl", rv, 8'h7f);
    wr(`PTS_ADDR_CTRL, 8'h00);
  endtask

  task automatic t_pre(logic [1:0] code, int ratio);
    logic [7:0] v0;
    wr(`PTS_ADDR_COUNT, 8'h00); wr(`PTS_ADDR_CTRL, {6'h01, code});
    rd(0); v0 = rv;
    for (int i = 0; i < 80 && rv == v0; i++) rd(0);
    t0 = cyc; v0 = rv;
    for (int i = 0; i < 80 && rv == v0; i++) rd(0);
    chk("tick step", cyc - t0, 4 * ratio);
    chk("increment", rv, v0 + 1);
  endtask

  task automatic t_wrap();
    wr(`PTS_ADDR_PERIOD, 8'h02); wr(`PTS_ADDR_COUNT, 8'h00);
    wr(`PTS_ADDR_CTRL, 8'h04);
    for (int i = 0; i < 30; i++) begin
      rd(0);
      chk("bounded", rv <= 2, 1);
    end
  endtask

  task automatic t_post(int n);
    wr(`PTS_ADDR_CTRL, 8'h00); rd(`PTS_ADDR_FLAG);
    wr(`PTS_ADDR_PERIOD, 8'h01); wr(4, 8'h01); wr(0, 8'h00);
    wr(`PTS_ADDR_CTRL, {1'b0, 4'(n - 1), 3'b100});
    wait_irq(); t0 = cyc;
    chk("irq", irq, 1);
    rd(`PTS_ADDR_FLAG); chk("flag", rv, 1);
    chk("irq cleared", irq, 0);
    wait_irq();
    chk("post span", cyc - t0, 8 * n);
  endtask

  task automatic t_stop();
    logic [7:0] v;
    wr(`PTS_ADDR_CTRL, 8'h00); rd(0); v = rv; rd(3);
    repeat (60) @(posedge mclk);
    rd(0); chk("held", rv, v);
    rd(3); chk("no flag", rv, 0);
    wr(`PTS_ADDR_CTRL, 8'h02); rd(0); chk("ctrl keeps", rv, v);
    wr(4, 8'h00); wr(`PTS_ADDR_CTRL, 8'h04);
    repeat (40) @(posedge mclk);
    chk("masked", irq, 0);
    rd(3); chk("flag set", rv, 1);
  endtask

  task automatic t_reset();
    wr(4, 8'h01); wr(`PTS_ADDR_CTRL, 8'h04);
    repeat (30) @(posedge mclk);
    chk("irq before reset", irq, 1);
    srst <= 1'b1;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk("irq after reset", irq, 0);
    rd(0); chk("count reset", rv, 8'h00);
    rd(1); chk("period reset", rv, 8'hff);
    rd(3); chk("flag reset", rv, 0);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    srst = 1'b1; clk_en = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0;
    addr = 4'h0; wdata = 8'h00;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_pre(2'b00, 1); t_pre(2'b01, 4); t_pre(2'b10, 16); t_pre(2'b11, 16);
    t_wrap();
    for (int n = 1; n <= 16; n++) t_post(n);
    t_stop();
    clk_en <= 1'b0; wr(1, 8'h33); clk_en <= 1'b1;
    rd(1); chk("frozen", rv, 8'h01);
    t_reset();
    report_and_stop();
  end
endmodule
